// ===== adch_pkg.sv
// Package: timing constants and states for the converter host controller
package adch_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int DATA_W        = 16;
	localparam int BYTE_W        = 8;
	localparam int CNT_W         = 8;
	// Host-side minimum times in ns, and device busy times
	localparam int T_TRIG_LOW_NS   = 20;
	localparam int T_TRIG_HIGH_NS  = 20;
	localparam int T_QUIET_NS      = 40;
	localparam int T_RD_LOW_NS     = 50;
	localparam int T_RD_HIGH_NS    = 20;
	localparam int T_RD_TO_TRIG_NS = 50;
	localparam int T_ACQ_NS        = 150;
	localparam int T_BUSY_MAX_NS   = 630;
	localparam int T_BUSY_RISE_NS  = 40;
	// Least times round up, longest times round down, never below one cycle
	function automatic int ns_min_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	function automatic int ns_max_cyc(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int C_TRIG_LOW   = ns_min_cyc(T_TRIG_LOW_NS);
	localparam int C_TRIG_HIGH  = ns_min_cyc(T_TRIG_HIGH_NS);
	localparam int C_QUIET      = ns_min_cyc(T_QUIET_NS);
	localparam int C_RD_LOW     = ns_min_cyc(T_RD_LOW_NS);
	localparam int C_RD_HIGH    = ns_min_cyc(T_RD_HIGH_NS);
	localparam int C_RD_TO_TRIG = ns_min_cyc(T_RD_TO_TRIG_NS);
	localparam int C_ACQ        = ns_min_cyc(T_ACQ_NS);
	// Longest busy time plus busy rise time plus 4 cycles: beyond this the device is hung
	localparam int C_BUSY_TMO   = ns_max_cyc(T_BUSY_MAX_NS) + ns_min_cyc(T_BUSY_RISE_NS) + 4;
	localparam logic [BYTE_W-1:0] FOLD_FILL = 8'hFF;
	typedef enum logic [3:0] {
		ADCH_IDLE, ADCH_ACQ, ADCH_TRIG, ADCH_QUIET, ADCH_BUSY,
		ADCH_RD_LOW, ADCH_RD_HIGH, ADCH_PUSH, ADCH_GAP
	} adch_state_e;
endpackage

// ===== adch_host.sv
// Host controller: starts conversions and reads results over the parallel bus
module adch_host
	import adch_pkg::*;
#(
	parameter int DATA_WIDTH = adch_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// User control
	input  wire logic                      start,
	input  wire logic                      byte_mode,
	output logic                           ready_out,
	output logic                           timeout_err,
	// Result stream
	output logic [DATA_WIDTH-1:0]          res_data,
	output logic                           res_valid,
	input  wire logic                      res_ready,
	// Device pins
	output logic                           conversion_trigger_n,
	output logic                           cs_n,
	output logic                           rd_n,
	output logic                           byte_sel,
	input  wire logic                      busy,
	input  wire logic [DATA_WIDTH-1:0]     db_in
);
	import adch_pkg::*;

	// ************************************************
	// Pin synchronisers
	// ************************************************
	logic                  busy_m_reg, busy_s_reg;
	logic [DATA_WIDTH-1:0] db_m_reg, db_s_reg;
	always_ff @(posedge clk) begin
		busy_m_reg <= busy;
		busy_s_reg <= busy_m_reg;
		db_m_reg   <= db_in;
		db_s_reg   <= db_m_reg;
	end

	// ************************************************
	// Two-entry output buffer
	// ************************************************
	logic [DATA_WIDTH-1:0] buf_reg [2];
	logic [DATA_WIDTH-1:0] buf_next [2];
	logic                  rp_reg, rp_next, wp_reg, wp_next;
	logic [1:0]            cnt_reg, cnt_next;
	logic                  push;
	logic [DATA_WIDTH-1:0] push_data;
	logic                  buf_ready;
	logic                  pop;

	assign buf_ready = (cnt_reg != 2'd2);
	assign pop       = res_valid && res_ready;

	always_comb begin
		buf_next = buf_reg;
		wp_next  = wp_reg;
		rp_next  = rp_reg;
		cnt_next = cnt_reg;
		if (push && buf_ready) begin
			buf_next[wp_reg] = push_data;
			wp_next          = ~wp_reg;
		end
		if (pop)
			rp_next = ~rp_reg;
		cnt_next = cnt_reg + 2'((push && buf_ready) ? 1 : 0) - 2'(pop ? 1 : 0);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wp_reg  <= 1'b0;
			rp_reg  <= 1'b0;
			cnt_reg <= 2'd0;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
		buf_reg <= buf_next;
	end

	// Output registers mirror the head of the buffer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			res_valid <= 1'b0;
			res_data  <= '0;
		end else begin
			res_valid <= (cnt_next != 2'd0);
			res_data  <= buf_next[rp_next];
		end
	end

	// ************************************************
	// Conversion and read sequencer
	// ************************************************
	adch_state_e       st_reg, st_next;
	logic [CNT_W-1:0]  tm_reg, tm_next;
	logic              conv_n_next, cs_next, rd_next, bsel_next, err_next, rdy_next;
	logic              half_reg, half_next;
	logic [BYTE_W-1:0] hi_reg, hi_next;
	logic              mode_reg, mode_next;
	logic [DATA_WIDTH-1:0] wd_reg, wd_next;

	always_comb begin
		st_next     = st_reg;
		tm_next     = (tm_reg != '0) ? tm_reg - 1'b1 : tm_reg;
		conv_n_next = conversion_trigger_n;
		cs_next     = cs_n;
		rd_next     = rd_n;
		bsel_next   = byte_sel;
		err_next    = timeout_err;
		rdy_next    = 1'b0;
		half_next   = half_reg;
		hi_next     = hi_reg;
		mode_next   = mode_reg;
		wd_next     = wd_reg;
		push        = 1'b0;
		push_data   = wd_reg;
		case (st_reg)
			ADCH_IDLE: begin
				// Acquisition time runs from the synchronised busy fall
				if (busy_s_reg)
					tm_next = CNT_W'(C_ACQ);
				// Ready only when a start would be taken, so no start is lost
				rdy_next = (tm_reg == '0) && !busy_s_reg;
				// Wait out acquisition and strobe-to-trigger spacing
				if (start && tm_reg == '0 && !busy_s_reg) begin
					mode_next   = byte_mode;
					cs_next     = 1'b0;
					conv_n_next = 1'b0;
					bsel_next   = 1'b0;
					tm_next     = CNT_W'(C_TRIG_LOW);
					rdy_next    = 1'b0;
					st_next     = ADCH_TRIG;
				end
			end
			ADCH_TRIG: begin
				if (tm_reg <= CNT_W'(1)) begin
					conv_n_next = 1'b1;
					// Quiet time counted from the trigger fall
					tm_next     = CNT_W'(C_QUIET - C_TRIG_LOW);
					st_next     = ADCH_QUIET;
				end
			end
			ADCH_QUIET: begin
				if (tm_reg <= CNT_W'(1)) begin
					tm_next = CNT_W'(C_BUSY_TMO);
					st_next = ADCH_BUSY;
				end
			end
			ADCH_BUSY: begin
				// Read only after busy is seen low
				if (!busy_s_reg && tm_reg <= CNT_W'(C_BUSY_TMO - 2 * C_TRIG_LOW - 2)) begin
					rd_next   = 1'b0;
					bsel_next = mode_reg;
					half_next = 1'b0;
					tm_next   = CNT_W'(C_RD_LOW + 2);
					st_next   = ADCH_RD_LOW;
				end else if (tm_reg == '0) begin
					err_next  = 1'b1;
					cs_next   = 1'b1;
					tm_next   = CNT_W'(C_ACQ);
					st_next   = ADCH_IDLE;
				end
			end
			ADCH_RD_LOW: begin
				// Strobe stays low for its minimum plus the pin sync delay
				if (tm_reg <= CNT_W'(1)) begin
					rd_next = 1'b1;
					tm_next = CNT_W'(C_RD_HIGH);
					if (mode_reg && !half_reg) begin
						// Folded read: result low byte on upper lines
						hi_next = db_s_reg[DATA_WIDTH-1 -: BYTE_W];
						st_next = ADCH_RD_HIGH;
					end else begin
						// Latch the word now: the bus is released once the strobe rises
						wd_next = mode_reg ? {db_s_reg[DATA_WIDTH-1 -: BYTE_W], hi_reg}
						                   : db_s_reg;
						st_next = ADCH_PUSH;
					end
				end
			end
			ADCH_RD_HIGH: begin
				if (tm_reg <= CNT_W'(1)) begin
					rd_next   = 1'b0;
					bsel_next = 1'b0;
					half_next = 1'b1;
					tm_next   = CNT_W'(C_RD_LOW + 2);
					st_next   = ADCH_RD_LOW;
				end
			end
			ADCH_PUSH: begin
				push      = 1'b1;
				push_data = wd_reg;
				if (buf_ready) begin
					cs_next   = 1'b1;
					bsel_next = 1'b0;
					tm_next   = CNT_W'((C_RD_TO_TRIG > C_ACQ) ? C_RD_TO_TRIG : C_ACQ);
					st_next   = ADCH_IDLE;
				end
			end
			default: st_next = ADCH_IDLE;
		endcase
		if (start && st_reg == ADCH_IDLE)
			err_next = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg               <= ADCH_IDLE;
			tm_reg               <= CNT_W'(C_ACQ);
			conversion_trigger_n <= 1'b1;
			cs_n                 <= 1'b1;
			rd_n                 <= 1'b1;
			byte_sel             <= 1'b0;
			timeout_err          <= 1'b0;
			ready_out            <= 1'b0;
			half_reg             <= 1'b0;
			hi_reg               <= '0;
			mode_reg             <= 1'b0;
			wd_reg               <= '0;
		end else begin
			st_reg               <= st_next;
			tm_reg               <= tm_next;
			conversion_trigger_n <= conv_n_next;
			cs_n                 <= cs_next;
			rd_n                 <= rd_next;
			byte_sel             <= bsel_next;
			timeout_err          <= err_next;
			ready_out            <= rdy_next;
			half_reg             <= half_next;
			hi_reg               <= hi_next;
			mode_reg             <= mode_next;
			wd_reg               <= wd_next;
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	a_trig_low_width: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(conversion_trigger_n) |-> !$past(conversion_trigger_n, C_TRIG_LOW))
		else $error("trigger low too short");
	a_trig_high_width: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(conversion_trigger_n) |=> conversion_trigger_n)
		else $error("trigger high too short");
	a_cs_before_trig: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(conversion_trigger_n) |-> !cs_n)
		else $error("chip select late for trigger");
	a_quiet_after_trig: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(conversion_trigger_n) |-> (rd_n && $stable(byte_sel)) [*1] ##1 rd_n)
		else $error("bus activity during quiet time");
	a_cs_before_rd: assert property (@(posedge clk) disable iff (sys_rst)
		!rd_n |-> !cs_n)
		else $error("strobe low without chip select");
	a_rd_before_cs: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(cs_n) |-> $past(rd_n))
		else $error("chip select released under low strobe");
	a_rd_low_width: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(rd_n) |-> !rd_n [*2])
		else $error("strobe low too short");
	a_rd_high_width: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(rd_n) |-> $past(rd_n, C_RD_HIGH))
		else $error("strobe high too short");
	a_rd_to_trig: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(rd_n) |-> conversion_trigger_n [*2])
		else $error("trigger too soon after read");
	a_bsel_setup: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(rd_n) && byte_sel |-> mode_reg)
		else $error("byte select high outside byte mode");
	a_read_after_busy: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(rd_n) && !half_next |-> !$past(busy_s_reg))
		else $error("read started while busy");
	a_acq_before_trig: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(conversion_trigger_n) |-> !busy_s_reg && !$past(busy_s_reg, C_ACQ))
		else $error("trigger before acquisition time");
	a_start_taken: assert property (@(posedge clk) disable iff (sys_rst)
		ready_out && start && conversion_trigger_n |=> !conversion_trigger_n && !cs_n)
		else $error("start not taken while ready");
	a_timeout_release: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(timeout_err) |-> cs_n && rd_n)
		else $error("bus not released on timeout");
endmodule

// ===== adch_dev_model.sv
// Behavioural converter device model that answers the host controller
module adch_dev_model
	import adch_pkg::*;
(
	// Host pins
	input  wire logic              conversion_trigger_n,
	input  wire logic              cs_n,
	input  wire logic              rd_n,
	input  wire logic              byte_sel,
	// Bench control
	input  wire logic              hang,
	input  wire logic [DATA_W-1:0] sample,
	input  wire logic [9:0]        conv_ns,
	// Device outputs
	output logic                   busy,
	output logic [DATA_W-1:0]      db,
	output int                     viol
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] word = '0;
	realtime           t_tf = -1000.0;
	realtime           t_tr = -1000.0;
	realtime           t_rf = -1000.0;
	realtime           t_rr = -1000.0;
	realtime           t_bf = -1000.0;
	initial begin
		busy = 1'b0;
		db = '0;
		viol = 0;
	end
	// ****************
	// Conversion
	// ****************
	always @(negedge conversion_trigger_n) begin
		if ($realtime - t_bf < 150.0)
			viol++;
		if ($realtime - t_rr < 50.0 || $realtime - t_tr < 20.0)
			viol++;
		t_tf = $realtime;
		// Select and trigger move on one clock edge: look once both have settled
		#1;
		if (cs_n !== 1'b0)
			viol++;
		#29 busy = 1'b1;
		if (hang)
			wait (!hang);
		else
			#(conv_ns) word = sample;
		busy = 1'b0;
		t_bf = $realtime;
	end
	always @(posedge conversion_trigger_n) begin
		if ($realtime - t_tf < 20.0)
			viol++;
		t_tr = $realtime;
	end
	// ****************
	// Read bus
	// ****************
	always @(negedge rd_n) begin
		if (cs_n !== 1'b0 || busy !== 1'b0)
			viol++;
		if ($realtime - t_tf < 40.0 || $realtime - t_rr < 20.0)
			viol++;
		t_rf = $realtime;
	end
	always @(posedge rd_n) begin
		if ($realtime - t_rf < 50.0)
			viol++;
		t_rr = $realtime;
	end
	always @(posedge cs_n)
		if (rd_n === 1'b0)
			viol++;
	always @(byte_sel)
		if ($realtime - t_tf < 40.0)
			viol++;
	// Released bus shows the inverse of its last value
	always @(cs_n, rd_n, byte_sel, word)
		db <= #15 (cs_n === 1'b0 && rd_n === 1'b0) ?
			(byte_sel ? {word[7:0], 8'hFF} : word) : ~db;
endmodule

// ===== test_adch_host.sv
// Testbench for the converter host controller
module test_adch_host;
	timeunit 1ns;
	timeprecision 1ns;
	import adch_pkg::*;
	logic              clk, sys_rst, start, byte_mode, res_ready, hang;
	logic              ready_out, timeout_err, res_valid, trig_n, cs_n, rd_n, byte_sel, busy;
	logic [DATA_W-1:0] res_data, db, sample;
	logic [9:0]        conv_ns;
	int                viol;
	int                mismatches = 0;
	int                checks_done = 0;
	adch_host adch_host_inst (.clk(clk), .sys_rst(sys_rst), .start(start),
		.byte_mode(byte_mode), .ready_out(ready_out), .timeout_err(timeout_err),
		.res_data(res_data), .res_valid(res_valid), .res_ready(res_ready),
		.conversion_trigger_n(trig_n), .cs_n(cs_n), .rd_n(rd_n),
		.byte_sel(byte_sel), .busy(busy), .db_in(db));
	adch_dev_model adch_dev_model_inst (.conversion_trigger_n(trig_n), .cs_n(cs_n),
		.rd_n(rd_n), .byte_sel(byte_sel), .hang(hang), .sample(sample),
		.conv_ns(conv_ns), .busy(busy), .db(db), .viol(viol));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic stop_test();
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic kick(input logic bm, input logic [15:0] smp);
		int n;
		n = 0;
		// Let the previous start reach the design before looking at ready
		@(posedge clk);
		while (ready_out !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		sample <= smp;
		byte_mode <= bm;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask
	task automatic take(input logic [15:0] exp);
		int n;
		n = 0;
		@(posedge clk);
		while (!(res_valid === 1'b1 && res_ready === 1'b1) && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(res_data, exp);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_word();
		kick(1'b0, 16'hA53C);
		take(16'hA53C);
	endtask
	task automatic t_fold();
		conv_ns <= 10'd610;
		kick(1'b1, 16'h5AC3);
		take(16'h5AC3);
	endtask
	task automatic t_stall();
		res_ready <= 1'b0;
		kick(1'b0, 16'h1234);
		kick(1'b1, 16'hFEDC);
		kick(1'b0, 16'h0F0F);
		repeat (60) @(posedge clk);
		chk(res_data, 16'h1234);
		res_ready <= 1'b1;
		take(16'h1234);
		take(16'hFEDC);
		take(16'h0F0F);
	endtask
	task automatic t_hang();
		hang <= 1'b1;
		kick(1'b0, 16'h7777);
		repeat (40) @(posedge clk);
		chk({15'h0000, timeout_err}, 16'h0001);
		chk({15'h0000, res_valid}, 16'h0000);
		hang <= 1'b0;
		kick(1'b1, 16'h8001);
		take(16'h8001);
		chk({15'h0000, timeout_err}, 16'h0000);
	endtask
	initial begin
		sys_rst = 1'b1;
		start = 1'b0;
		byte_mode = 1'b0;
		res_ready = 1'b1;
		hang = 1'b0;
		sample = '0;
		conv_ns = 10'd600;
		repeat (3) @(posedge clk);
		chk({13'h0000, trig_n, cs_n, rd_n}, 16'h0007);
		sys_rst <= 1'b0;
		t_word();
		t_fold();
		t_stall();
		t_hang();
		chk(viol[15:0], 16'h0000);
		stop_test();
	end
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end
endmodule
